// >>> cell_result_pkg.sv
package cell_result_pkg;

    // ==========================================================
    // Sizes
    localparam int NUM_CH = 4;
    localparam int CODE_W = 14;
    localparam int ACC_W = 16;
    localparam int REG_W = 16;
    localparam int CODE_LSB = 2;
    localparam int ADDR_W = 12;
    localparam int FULL_SCALE_MV = 5000;

    // ==========================================================
    // Register indices, byte address is four times the index
    localparam logic [7:0] IDX_CH_FIVE = 8'h4B;
    localparam logic [7:0] IDX_CH_SIX = 8'h4C;
    localparam logic [7:0] IDX_CH_SEVEN = 8'h4D;
    localparam logic [7:0] IDX_CH_EIGHT = 8'h4E;
    localparam logic [7:0] IDX_SCAN_CTRL = 8'h60;

    // ==========================================================
    // Control fields and reset values
    localparam int ENABLE_LSB = 0;
    localparam int FILT_SEL_BIT = 8;
    localparam logic [NUM_CH-1:0] ENABLE_RESET = 4'hF;
    localparam logic FILT_SEL_RESET = 1'b0;
    localparam logic [CODE_W-1:0] CODE_RESET = 14'h0000;
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic done;
        logic [NUM_CH-1:0] measured;
        logic [NUM_CH-1:0][ACC_W-1:0] alu;
        logic [NUM_CH-1:0][ACC_W-1:0] iir;
    } scan_result_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_t;

    function automatic logic [ADDR_W-1:0] byteAddr(input logic [7:0] idx);
        byteAddr = {2'b00, idx, 2'b00};
    endfunction

endpackage

// >>> cell_result_channel.sv
`timescale 1ns/10ps
module cell_result_channel #(
    parameter int ACC_W = 16,
    parameter int CODE_W = 14
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic load,
    input wire logic [ACC_W-1:0] aluAcc,
    input wire logic [ACC_W-1:0] iirAcc,
    input wire logic filtSel,
    output logic [CODE_W-1:0] rawCode,
    output logic [CODE_W-1:0] filtCode,
    output logic [CODE_W-1:0] readCode
);

    // ==========================================================
    // Checks
    if (ACC_W < CODE_W || CODE_W != 14) begin : g_bad_width
        $error("cell_result_channel: unsupported widths");
    end

    // Top bits of the full accumulator span map onto the 5V code range
    function automatic logic [CODE_W-1:0] scaleCode(input logic [ACC_W-1:0] acc);
        scaleCode = acc[ACC_W-1 -: CODE_W];
    endfunction

    // ==========================================================
    // Storage
    logic [CODE_W-1:0] raw_r, raw_nxt;
    logic [CODE_W-1:0] filt_r, filt_nxt;

    always_comb begin
        raw_nxt = raw_r;
        filt_nxt = filt_r;
        if (load) begin
            raw_nxt = scaleCode(aluAcc);
            filt_nxt = scaleCode(iirAcc);
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            raw_r <= cell_result_pkg::CODE_RESET;
            filt_r <= cell_result_pkg::CODE_RESET;
        end else begin
            raw_r <= raw_nxt;
            filt_r <= filt_nxt;
        end
    end

    assign rawCode = raw_r;
    assign filtCode = filt_r;
    // Filter choice applies to held values too
    assign readCode = filtSel ? filt_r : raw_r;

endmodule

// >>> cell_result_regs.sv
`timescale 1ns/10ps

module cell_result_regs #(
    parameter int NUM_CH = 4
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire cell_result_pkg::apb_req_t apbReq,
    output cell_result_pkg::apb_rsp_t apbRsp,
    input wire cell_result_pkg::scan_result_t scanIn,
    output logic [3:0] channelScanEnable,
    output logic readbackFilterSelect
);

    // ==========================================================
    // Elaboration checks
    if (NUM_CH != cell_result_pkg::NUM_CH) begin : g_bad_count
        $error("cell_result_regs: channel count must match the map");
    end
    if (cell_result_pkg::ENABLE_LSB + NUM_CH > cell_result_pkg::FILT_SEL_BIT) begin : g_bad_map
        $error("cell_result_regs: enable field overlaps the filter bit");
    end

    localparam int CW = cell_result_pkg::CODE_W;
    localparam int AW = cell_result_pkg::ADDR_W;

    // ==========================================================
    // Per-channel storage
    logic [NUM_CH-1:0] chLoad;
    logic [CW-1:0] rawCode [NUM_CH];
    logic [CW-1:0] filtCode [NUM_CH];
    logic [CW-1:0] readCode [NUM_CH];

    logic [3:0] enable_r, enable_nxt;
    logic filtSel_r, filtSel_nxt;

    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
        // Skipped channels keep old data; only a real measurement loads
        assign chLoad[i] = scanIn.done & scanIn.measured[i];

        cell_result_channel #(
            .ACC_W(cell_result_pkg::ACC_W),
            .CODE_W(CW)
        ) u_ch (
            .sys_clk(sys_clk),
            .sys_rst(sys_rst),
            .load(chLoad[i]),
            .aluAcc(scanIn.alu[i]),
            .iirAcc(scanIn.iir[i]),
            .filtSel(filtSel_r),
            .rawCode(rawCode[i]),
            .filtCode(filtCode[i]),
            .readCode(readCode[i])
        );
    end

    // ==========================================================
    // Address decode
    logic setupCyc;
    logic accessCyc;
    logic [AW-1:0] addr;
    logic hitResult;
    logic hitCtrl;
    logic [1:0] resultSel;

    assign addr = apbReq.paddr;
    assign setupCyc = apbReq.psel & ~apbReq.penable;
    assign accessCyc = apbReq.psel & apbReq.penable & apbRsp.pready;

    always_comb begin
        hitResult = 1'b1;
        resultSel = 2'h0;
        hitCtrl = (addr == cell_result_pkg::byteAddr(cell_result_pkg::IDX_SCAN_CTRL));
        unique case (addr)
            cell_result_pkg::byteAddr(cell_result_pkg::IDX_CH_FIVE): resultSel = 2'h0;
            cell_result_pkg::byteAddr(cell_result_pkg::IDX_CH_SIX): resultSel = 2'h1;
            cell_result_pkg::byteAddr(cell_result_pkg::IDX_CH_SEVEN): resultSel = 2'h2;
            cell_result_pkg::byteAddr(cell_result_pkg::IDX_CH_EIGHT): resultSel = 2'h3;
            default: hitResult = 1'b0;
        endcase
    end

    // ==========================================================
    // Bus answer, one wait-free access phase
    cell_result_pkg::apb_rsp_t rsp_r, rsp_nxt;

    always_comb begin
        rsp_nxt.pready = setupCyc;
        rsp_nxt.pslverr = 1'b0;
        rsp_nxt.prdata = cell_result_pkg::READ_ZERO;
        if (setupCyc) begin
            if (hitResult && !apbReq.pwrite) begin
                // Code sits above two zero bits
                rsp_nxt.prdata = {16'h0000, readCode[resultSel], 2'b00};
            end else if (hitResult) begin
                // Write to a result register flagged, storage untouched
                rsp_nxt.pslverr = 1'b1;
            end else if (hitCtrl) begin
                rsp_nxt.prdata[cell_result_pkg::ENABLE_LSB +: 4] = enable_r;
                rsp_nxt.prdata[cell_result_pkg::FILT_SEL_BIT] = filtSel_r;
            end else begin
                rsp_nxt.pslverr = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rsp_r <= '0;
        end else begin
            rsp_r <= rsp_nxt;
        end
    end

    assign apbRsp = rsp_r;

    // ==========================================================
    // Scan control register
    always_comb begin
        enable_nxt = enable_r;
        filtSel_nxt = filtSel_r;
        // Only the control word is writable
        if (accessCyc && apbReq.pwrite && hitCtrl) begin
            enable_nxt = apbReq.pwdata[cell_result_pkg::ENABLE_LSB +: 4];
            filtSel_nxt = apbReq.pwdata[cell_result_pkg::FILT_SEL_BIT];
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            enable_r <= cell_result_pkg::ENABLE_RESET;
            filtSel_r <= cell_result_pkg::FILT_SEL_RESET;
        end else begin
            enable_r <= enable_nxt;
            filtSel_r <= filtSel_nxt;
        end
    end

    assign channelScanEnable = enable_r;
    assign readbackFilterSelect = filtSel_r;

    // ==========================================================
    // Assertions
    sequence s_read_five;
        setupCyc && !apbReq.pwrite &&
            addr == cell_result_pkg::byteAddr(cell_result_pkg::IDX_CH_FIVE);
    endsequence

    sequence s_write_result;
        accessCyc && apbReq.pwrite && hitResult;
    endsequence

    sequence s_skip_zero;
        scanIn.done && !scanIn.measured[0] && !enable_r[0];
    endsequence

    a_code_position: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        s_read_five |=> apbRsp.pready &&
            apbRsp.prdata[15:2] == $past(readCode[0]) && apbRsp.prdata[31:16] == 16'h0000)
    else $error("channel five code not in bits 15 to 2");

    a_scale_load: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        scanIn.done && scanIn.measured[1] |=>
            rawCode[1] == $past(scanIn.alu[1][15:2]) &&
            filtCode[1] == $past(scanIn.iir[1][15:2]))
    else $error("loaded code not scaled from accumulator top bits");

    a_skip_holds: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        s_skip_zero |=> $stable(rawCode[0]) && $stable(filtCode[0]))
    else $error("skipped disabled channel data changed");

    a_filter_choice: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        s_read_five |=> apbRsp.prdata[15:2] ==
            ($past(filtSel_r) ? $past(filtCode[0]) : $past(rawCode[0])))
    else $error("readback ignores filter selection");

    a_write_ignored: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        s_write_result ##0 !scanIn.done |=>
            $stable(rawCode[2]) && $stable(filtCode[2]) && $stable(enable_r))
    else $error("write to result register altered state");

    a_write_error: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        setupCyc && apbReq.pwrite && hitResult |=> apbRsp.pready && apbRsp.pslverr)
    else $error("write to result register not flagged");

    a_low_bits_zero: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        apbRsp.pready && $past(hitResult) |-> apbRsp.prdata[1:0] == 2'b00)
    else $error("unused low bits not zero");

    a_ready_once: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        apbRsp.pready |=> !apbRsp.pready || !$past(apbReq.penable))
    else $error("ready held past the access phase");

    sequence s_ctrl_write;
        accessCyc && apbReq.pwrite && hitCtrl;
    endsequence

    sequence s_unmapped;
        setupCyc && !hitResult && !hitCtrl;
    endsequence

    a_ctrl_update: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        s_ctrl_write |=>
            channelScanEnable == $past(apbReq.pwdata[cell_result_pkg::ENABLE_LSB +: 4]) &&
            readbackFilterSelect == $past(apbReq.pwdata[cell_result_pkg::FILT_SEL_BIT]))
    else $error("control write did not land");

    // Result writes must not leak into the control word either
    a_ctrl_hold: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        !(accessCyc && apbReq.pwrite && hitCtrl) |=>
            $stable(enable_r) && $stable(filtSel_r))
    else $error("control changed without a control write");

    a_ctrl_readback: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        setupCyc && !apbReq.pwrite && hitCtrl |=> apbRsp.pready && !apbRsp.pslverr &&
            apbRsp.prdata[cell_result_pkg::ENABLE_LSB +: 4] == $past(enable_r) &&
            apbRsp.prdata[cell_result_pkg::FILT_SEL_BIT] == $past(filtSel_r))
    else $error("control readback wrong");

    a_unmapped_error: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        s_unmapped |=> apbRsp.pready && apbRsp.pslverr && apbRsp.prdata == 32'h0000_0000)
    else $error("unmapped access not refused");

    a_read_accepted: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        setupCyc && !apbReq.pwrite && hitResult |=> apbRsp.pready && !apbRsp.pslverr)
    else $error("result read refused");

    // No wait states: the answer is always the cycle after setup
    a_ready_after_setup: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        setupCyc |=> apbRsp.pready)
    else $error("no answer after setup");

    a_ready_only_setup: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        !setupCyc |=> !apbRsp.pready)
    else $error("answer without setup");

    a_error_with_ready: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        apbRsp.pslverr |-> apbRsp.pready)
    else $error("error flag outside the answer");

    // Idle bus shows zero so stale codes never linger on the data lines
    a_idle_data_zero: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        !apbRsp.pready |-> apbRsp.prdata == 32'h0000_0000 && !apbRsp.pslverr)
    else $error("data or error driven while idle");

    // ==========================================================
    // Per-channel assertions, all four channels
    for (genvar j = 0; j < NUM_CH; j++) begin : g_chk
        localparam logic [7:0] CH_IDX = 8'(cell_result_pkg::IDX_CH_FIVE + j);
        localparam logic [AW-1:0] CH_ADDR = cell_result_pkg::byteAddr(CH_IDX);

        sequence s_measured;
            scanIn.done && scanIn.measured[j];
        endsequence

        sequence s_read_ch;
            setupCyc && !apbReq.pwrite && addr == CH_ADDR;
        endsequence

        a_load_each: assert property (
            @(posedge sys_clk) disable iff (sys_rst)
            s_measured |=>
                rawCode[j] == $past(scanIn.alu[j][15:2]) &&
                filtCode[j] == $past(scanIn.iir[j][15:2]))
        else $error("channel code not loaded from accumulator top bits");

        // Any cycle without a measurement of this channel, skipped scans included
        a_hold_each: assert property (
            @(posedge sys_clk) disable iff (sys_rst)
            !(scanIn.done && scanIn.measured[j]) |=>
                $stable(rawCode[j]) && $stable(filtCode[j]))
        else $error("channel data changed without a measurement");

        a_read_each: assert property (
            @(posedge sys_clk) disable iff (sys_rst)
            s_read_ch |=> apbRsp.pready && !apbRsp.pslverr &&
                apbRsp.prdata == {16'h0000,
                    ($past(filtSel_r) ? $past(filtCode[j]) : $past(rawCode[j])), 2'b00})
        else $error("channel readback word wrong");
    end

endmodule

// >>> cell_voltage_result_regs_test.sv
`timescale 1ns/10ps
module cell_voltage_result_regs_test;
    // ==========================================================
    // Signals and model state
    logic sys_clk;
    logic sys_rst;
    cell_result_pkg::apb_req_t apbReq;
    cell_result_pkg::apb_rsp_t apbRsp;
    cell_result_pkg::scan_result_t scanIn;
    logic [3:0] channelScanEnable;
    logic readbackFilterSelect;
    int miscompares;
    int checks_done;
    int seed;
    int rawCode [4];
    int filtCode [4];
    int enableModel;
    int filtModel;
    logic [31:0] rdData;
    logic rdErr;

    cell_result_regs #(.NUM_CH(4)) dut (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .apbReq(apbReq),
        .apbRsp(apbRsp),
        .scanIn(scanIn),
        .channelScanEnable(channelScanEnable),
        .readbackFilterSelect(readbackFilterSelect)
    );

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    // ==========================================================
    // Shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] expected);
        checks_done++;
        if (seen !== expected) begin
            miscompares++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, expected);
        end
    endtask

    task automatic stop_test();
        if (miscompares == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Request held until pready is seen at a rising edge, or for at most 20 edges after penable
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] data);
        int n;
        @(posedge sys_clk);
        apbReq.psel <= 1'b1;
        apbReq.penable <= 1'b0;
        apbReq.pwrite <= wr;
        apbReq.paddr <= {2'b00, idx, 2'b00};
        apbReq.pwdata <= data;
        @(posedge sys_clk);
        apbReq.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (apbRsp.pready !== 1'b1 && n < 20);
        // A hang counts against the run, which still ends in the one verdict
        if (apbRsp.pready !== 1'b1) begin
            miscompares++;
        end
        rdData = apbRsp.prdata;
        rdErr = apbRsp.pslverr;
        apbReq.psel <= 1'b0;
        apbReq.penable <= 1'b0;
    endtask

    function automatic logic [31:0] expRes(input int ch);
        logic [31:0] c;
        c = (filtModel != 0) ? filtCode[ch] : rawCode[ch];
        return {16'h0000, c[13:0], 2'b00};
    endfunction

    task automatic readAll();
        for (int ch = 0; ch < 4; ch++) begin
            apb(1'b0, 8'(8'h4B + ch), 32'h0000_0000);
            check(rdData, expRes(ch));
            check({31'h0, rdErr}, 32'h0000_0000);
        end
    endtask

    // Skipped channels get fresh junk on the accumulators, which must not land
    task automatic scan(input logic full);
        logic [3:0] m;
        logic [15:0] a [4];
        logic [15:0] f [4];
        m = full ? 4'hF : 4'($random(seed));
        for (int i = 0; i < 4; i++) begin
            a[i] = full ? 16'hFFFF : 16'($random(seed));
            f[i] = full ? 16'h0003 : 16'($random(seed));
        end
        @(posedge sys_clk);
        scanIn.done <= 1'b1;
        scanIn.measured <= m;
        for (int i = 0; i < 4; i++) begin
            scanIn.alu[i] <= a[i];
            scanIn.iir[i] <= f[i];
            if (m[i]) begin
                rawCode[i] = a[i][15:2];
                filtCode[i] = f[i][15:2];
            end
        end
        @(posedge sys_clk);
        scanIn.done <= 1'b0;
    endtask

    task automatic setCtrl(input logic [31:0] w);
        apb(1'b1, 8'h60, w);
        enableModel = w[3:0];
        filtModel = w[8];
        @(posedge sys_clk);
        check({28'h0, channelScanEnable}, 32'(enableModel));
        check({31'h0, readbackFilterSelect}, 32'(filtModel));
        apb(1'b0, 8'h60, 32'h0000_0000);
        check(rdData, {23'h0, w[8], 4'h0, w[3:0]});
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        logic [7:0] k;
        seed = 32933;
        miscompares = 0;
        checks_done = 0;
        sys_rst = 1'b1;
        apbReq = '0;
        scanIn = '0;
        for (int i = 0; i < 4; i++) begin
            rawCode[i] = 0;
            filtCode[i] = 0;
        end
        enableModel = 15;
        filtModel = 0;
        repeat (8) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        check({28'h0, channelScanEnable}, 32'h0000_000F);
        readAll();
        scan(1'b1);
        readAll();
        setCtrl(32'h0000_0100);
        readAll();
        repeat (12) begin
            scan(1'b0);
            setCtrl(32'($random(seed)));
            readAll();
            k = 8'(8'h4B + ($random(seed) & 3));
            apb(1'b1, k, 32'($random(seed)));
            check({31'h0, rdErr}, 32'h0000_0001);
            apb(1'b0, k, 32'h0000_0000);
            check(rdData, expRes(k - 8'h4B));
        end
        apb(1'b0, 8'h4F, 32'h0000_0000);
        check(rdData, 32'h0000_0000);
        check({31'h0, rdErr}, 32'h0000_0001);
        stop_test();
    end
endmodule
